// ==== wdt_pkg.sv ====
// Purpose: Shared constants and types for the write-once watchdog timer
// Assumes: Byte-wide processor bus, 16-bit addresses
// Notes: Counter width covers the longest crystal interval
package wdt_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [15:0] WDT_MODE_ADDR = 16'hFF98;
  localparam logic [15:0] WDT_REFRESH_ADDR = 16'hFF99;
  localparam logic [7:0] WDT_MODE_RESET = 8'h67;
  localparam logic [2:0] WDT_MODE_FIXED = 3'h3;
  localparam logic [7:0] WDT_REFRESH_KEY = 8'hAC;
  localparam logic [7:0] WDT_REFRESH_READ = 8'h9A;
  // ----------------------------------------
  // Field layout of the mode and reset cause registers
  // ----------------------------------------
  localparam int WDT_STOP_BIT = 4;
  localparam int WDT_XTAL_BIT = 3;
  localparam int WDT_SEL_LSB = 0;
  localparam int WDT_SEL_W = 3;
  localparam int WDT_CFG_W = 5;
  localparam int WDT_CAUSE_BIT = 4;
  // ----------------------------------------
  // Interval exponents
  // ----------------------------------------
  localparam logic [4:0] WDT_OSC_EXP_BASE = 5'h0B;
  localparam logic [4:0] WDT_XTAL_EXP_BASE = 5'h0D;
  localparam int WDT_CNT_W = 21;

  typedef struct packed {
    logic wr;
    logic rd;
    logic bit_op;
    logic [15:0] addr;
    logic [7:0] wdata;
  } wdt_bus_t;

  typedef struct packed {
    logic halt;
    logic stop;
    logic xtal_stopped;
    logic osc_stab;
    logic cpu_xtal_sw_stopped;
  } wdt_standby_t;
endpackage

// ==== wdt_core.sv ====
// Purpose: Write-once watchdog timer with mode and refresh registers
// Assumes: Oscillator and crystal arrive as one-cycle tick enables
// Notes: o_wdt_reset is a one-cycle internal reset request
`timescale 1ns/1ps
module wdt_core
  import wdt_pkg::*;
#(
  parameter bit OSC_UNSTOPPABLE = 1'b0
)
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Processor bus
  input wire wdt_bus_t i_bus,
  output logic [7:0] o_rdata,
  output logic o_wait,
  // Count sources and standby state
  input wire logic i_osc_tick,
  input wire logic i_xtal_tick,
  input wire wdt_standby_t i_standby,
  // Reset cause handling
  input wire logic i_cause_clear,
  output logic o_wdt_reset,
  output logic [7:0] o_reset_cause
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [WDT_CFG_W-1:0] cfg_reg;
  logic written_reg;
  logic stopped_reg;
  logic pending_reg;
  logic [WDT_CNT_W-1:0] cnt_reg;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  logic mode_wr, mode_wr_full, ref_wr, ref_good, ref_bad, ref_rd, mode_rd;
  logic use_xtal, gated, tick_en, hit, violation, fire;
  logic [4:0] exp_sel;
  logic [WDT_CNT_W-1:0] limit_m1;

  assign mode_wr = i_bus.wr && (i_bus.addr == WDT_MODE_ADDR);
  // Bit accesses cannot set the mode register
  assign mode_wr_full = mode_wr && !i_bus.bit_op;
  assign ref_wr = (i_bus.wr || (i_bus.rd && i_bus.bit_op)) && (i_bus.addr == WDT_REFRESH_ADDR);
  assign ref_good = ref_wr && !i_bus.bit_op && (i_bus.wdata == WDT_REFRESH_KEY);
  assign ref_bad = ref_wr && !ref_good;
  assign ref_rd = i_bus.rd && !i_bus.bit_op && (i_bus.addr == WDT_REFRESH_ADDR);
  assign mode_rd = i_bus.rd && (i_bus.addr == WDT_MODE_ADDR);

  // Option forces the oscillator whatever the select bits hold
  assign use_xtal = !OSC_UNSTOPPABLE && cfg_reg[WDT_XTAL_BIT];
  always_comb
  begin
    if (OSC_UNSTOPPABLE)
    begin
      gated = 1'b0;
    end
    else if (use_xtal)
    begin
      gated = i_standby.xtal_stopped || i_standby.halt || i_standby.stop
        || i_standby.osc_stab;
    end
    else
    begin
      gated = i_standby.halt || i_standby.stop || i_standby.cpu_xtal_sw_stopped;
    end
  end

  assign tick_en = !stopped_reg && !gated && (use_xtal ? i_xtal_tick : i_osc_tick);
  assign exp_sel = (use_xtal ? WDT_XTAL_EXP_BASE : WDT_OSC_EXP_BASE)
    + {2'h0, cfg_reg[WDT_SEL_LSB +: WDT_SEL_W]};
  assign limit_m1 = (WDT_CNT_W'(1) << exp_sel) - WDT_CNT_W'(1);
  assign hit = tick_en && (cnt_reg == limit_m1);

  // Stopped timer swallows violations entirely
  assign violation = !stopped_reg && ((mode_wr_full && written_reg) || ref_bad);
  // Gated source defers a violation to the next source tick
  assign fire = hit || (violation && !gated) || (pending_reg && tick_en);

  // ----------------------------------------
  // Mode register, write-once
  // ----------------------------------------
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cfg_reg <= WDT_MODE_RESET[WDT_CFG_W-1:0];
      written_reg <= 1'b0;
      stopped_reg <= 1'b0;
    end
    else if (fire)
    begin
      cfg_reg <= WDT_MODE_RESET[WDT_CFG_W-1:0];
      written_reg <= 1'b0;
      stopped_reg <= 1'b0;
    end
    else if (mode_wr_full && !written_reg)
    begin
      written_reg <= 1'b1;
      if (OSC_UNSTOPPABLE)
      begin
        cfg_reg[WDT_SEL_LSB +: WDT_SEL_W] <= i_bus.wdata[WDT_SEL_LSB +: WDT_SEL_W];
      end
      else
      begin
        cfg_reg <= i_bus.wdata[WDT_CFG_W-1:0];
        stopped_reg <= i_bus.wdata[WDT_STOP_BIT];
      end
    end
  end

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cnt_reg <= '0;
    end
    else if (fire || ref_good || mode_wr_full)
    begin
      cnt_reg <= '0;
    end
    else if (tick_en)
    begin
      cnt_reg <= cnt_reg + WDT_CNT_W'(1);
    end
  end

  // ----------------------------------------
  // Deferred reset
  // ----------------------------------------
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      pending_reg <= 1'b0;
    end
    else if (fire)
    begin
      pending_reg <= 1'b0;
    end
    else if (violation && gated)
    begin
      pending_reg <= 1'b1;
    end
  end

  // ----------------------------------------
  // Reset request and cause flag
  // ----------------------------------------
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_wdt_reset <= 1'b0;
      o_reset_cause <= '0;
    end
    else
    begin
      o_wdt_reset <= fire;
      // Set beats a clear in the same cycle
      if (fire)
      begin
        o_reset_cause[WDT_CAUSE_BIT] <= 1'b1;
      end
      else if (i_cause_clear)
      begin
        o_reset_cause[WDT_CAUSE_BIT] <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Bus read data and wait
  // ----------------------------------------
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_rdata <= 8'h00;
      o_wait <= 1'b0;
    end
    else
    begin
      o_wait <= mode_wr;
      if (ref_rd)
      begin
        o_rdata <= WDT_REFRESH_READ;
      end
      else if (mode_rd)
      begin
        o_rdata <= {WDT_MODE_FIXED, cfg_reg};
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  sequence s_second_write;
    mode_wr_full && written_reg && !stopped_reg && !gated;
  endsequence
  sequence s_defer;
    violation && gated && !fire;
  endsequence

  property p_overflow;
    hit |=> o_wdt_reset && (cnt_reg == '0);
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow gave no reset");

  property p_cause;
    o_wdt_reset |-> o_reset_cause[WDT_CAUSE_BIT];
  endproperty
  a_cause: assert property (p_cause) else $error("cause flag not set");

  property p_interval;
    tick_en && !use_xtal && (cfg_reg[WDT_SEL_LSB +: WDT_SEL_W] == '0)
      |-> hit == (cnt_reg == (WDT_CNT_W'(1) << WDT_OSC_EXP_BASE) - WDT_CNT_W'(1));
  endproperty
  a_interval: assert property (p_interval) else $error("wrong overflow point");

  property p_gated;
    gated && !ref_good && !mode_wr_full |=> $stable(cnt_reg);
  endproperty
  a_gated: assert property (p_gated) else $error("gated source still counted");

  property p_second_write;
    s_second_write |=> o_wdt_reset;
  endproperty
  a_second_write: assert property (p_second_write) else $error("second write ignored");

  property p_defer;
    s_defer |=> pending_reg;
  endproperty
  a_defer: assert property (p_defer) else $error("reset not held pending");

  property p_stopped;
    stopped_reg |=> !o_wdt_reset && $stable(cnt_reg);
  endproperty
  a_stopped: assert property (p_stopped) else $error("stopped timer moved");

  property p_refresh;
    ref_good && !fire |=> (cnt_reg == '0) && !o_wdt_reset;
  endproperty
  a_refresh: assert property (p_refresh) else $error("refresh failed");

  property p_refresh_read;
    ref_rd |=> (o_rdata == WDT_REFRESH_READ);
  endproperty
  a_refresh_read: assert property (p_refresh_read) else $error("refresh read wrong");

  property p_wait;
    mode_wr |=> o_wait ##1 (!o_wait || $past(mode_wr));
  endproperty
  a_wait: assert property (p_wait) else $error("missing wait cycle");

  property p_unstoppable;
    OSC_UNSTOPPABLE |-> !stopped_reg && !use_xtal;
  endproperty
  a_unstoppable: assert property (p_unstoppable) else $error("option not honoured");
endmodule

// ==== wdt_sw_model.sv ====
// Purpose: Processor-side model issuing byte accesses to the watchdog
// Assumes: One access at a time, strobes launched from a clock edge
// Notes: Bit accesses only when the bench asks for them
`timescale 1ns/1ps
module wdt_sw_model
  import wdt_pkg::*;
(
  // Clock
  input wire logic i_clock,
  // Bus toward the watchdog
  output wdt_bus_t o_bus
);
  initial o_bus = '0;

  // Idle cycle after each access, so strobes never merge
  task automatic put(input logic wr, input logic bop, input logic [15:0] a,
    input logic [7:0] d);
    @(posedge i_clock);
    o_bus <= '{wr: wr, rd: !wr, bit_op: bop, addr: a, wdata: d};
    @(posedge i_clock);
    o_bus <= '0;
  endtask
endmodule

// ==== test_write_once_watchdog_timer.sv ====
// Purpose: Self-checking bench for the watchdog core
// Assumes: Both option settings, ticks drawn from an LFSR
// Notes: Short interval codes keep the run brief
`timescale 1ns/1ps
module test_write_once_watchdog_timer
  import wdt_pkg::*;
;
  logic clk = 0, rst_n = 0, cclr = 0, osc = 0, xt = 0, wt, wrst;
  wdt_bus_t bus;
  wdt_standby_t sb = '0;
  logic [7:0] rdata, rdata_u, cause, d;
  logic [15:0] lf = 16'h1348;
  int n_fail = 0, checks_done = 0, cyc = 0, tk = 0, tx = 0, n;

  wdt_sw_model sw (.i_clock(clk), .o_bus(bus));
  wdt_core #(.OSC_UNSTOPPABLE(1'h0)) dut (.i_clock(clk), .i_rst_n(rst_n),
    .i_bus(bus), .o_rdata(rdata), .o_wait(wt), .i_osc_tick(osc),
    .i_xtal_tick(xt), .i_standby(sb), .i_cause_clear(cclr),
    .o_wdt_reset(wrst), .o_reset_cause(cause));
  // Same traffic into the unstoppable option
  wdt_core #(.OSC_UNSTOPPABLE(1'h1)) dut_u (.i_clock(clk), .i_rst_n(rst_n),
    .i_bus(bus), .o_rdata(rdata_u), .o_wait(), .i_osc_tick(osc),
    .i_xtal_tick(xt), .i_standby(sb), .i_cause_clear(cclr),
    .o_wdt_reset(), .o_reset_cause());

  initial forever #5 clk = ~clk;

  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  function automatic int span(input int base, input logic [2:0] code);
    return 1 << (base + code);
  endfunction

  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      n_fail++;
      $display("wrong value %s exp %0h got %0h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    sw.put(1'h1, 1'h0, a, v);
    #1;
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    sw.put(1'h0, 1'h0, a, 8'h00);
    #1;
    chk("rdata", e, rdata);
  endtask

  // Bounded wait for the reset pulse
  task automatic hold(input int cap);
    n = 0;
    while (wrst !== 1'h1 && n < cap)
    begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask

  // ----------------------------------------
  // Random ticks, tick tally, timeout
  // ----------------------------------------
  always @(posedge clk)
  begin
    lf <= nxt(lf);
    osc <= lf[0];
    xt <= lf[1];
    if (osc)
      tk <= tk + 1;
    if (xt)
      tx <= tx + 1;
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      n_fail++;
      conclude();
    end
  end

  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'h1;
    rd(WDT_MODE_ADDR, WDT_MODE_RESET);
    rd(WDT_REFRESH_ADDR, WDT_REFRESH_READ);
    rd(16'hFFA0, WDT_REFRESH_READ);
    wr(WDT_REFRESH_ADDR, WDT_REFRESH_KEY);
    chk("refresh", 32'h0, wrst);
    wr(WDT_MODE_ADDR, 8'h60);
    chk("wait", 32'h1, wt);
    tk = 0;
    rd(WDT_MODE_ADDR, 8'h60);
    hold(9000);
    chk("osc span", 32'h1, tk >= span(11, 3'h0) - 1 && tk <= span(11, 3'h0) + 1);
    chk("cause", 32'h10, cause);
    @(posedge clk);
    cclr <= 1'h1;
    @(posedge clk);
    cclr <= 1'h0;
    rd(WDT_MODE_ADDR, WDT_MODE_RESET);
    chk("cause clear", 32'h0, cause);
    // Stabilisation gates the crystal source
    @(posedge clk);
    sb.osc_stab <= 1'h1;
    wr(WDT_MODE_ADDR, 8'h68);
    repeat (50) @(posedge clk);
    sb.osc_stab <= 1'h0;
    #1;
    tx = 0;
    hold(30000);
    chk("xtal span", 32'h1, tx >= span(13, 3'h0) - 1 && tx <= span(13, 3'h0) + 1);
    wr(WDT_MODE_ADDR, 8'h61);
    wr(WDT_MODE_ADDR, 8'h61);
    hold(3);
    chk("second write", 32'h1, wrst);
    d = lf[7:0];
    if (d == WDT_REFRESH_KEY)
      d = 8'h00;
    wr(WDT_REFRESH_ADDR, d);
    hold(3);
    chk("bad key", 32'h1, wrst);
    // Halted source: violation waits for the clock
    @(posedge clk);
    sb.halt <= 1'h1;
    sw.put(1'h0, 1'h1, WDT_REFRESH_ADDR, 8'h00);
    hold(40);
    chk("gated", 32'h0, wrst);
    @(posedge clk);
    sb.halt <= 1'h0;
    hold(40);
    chk("resumed", 32'h1, wrst);
    wr(WDT_MODE_ADDR, 8'h70);
    rd(WDT_MODE_ADDR, 8'h70);
    chk("unstoppable mode", 32'h60, rdata_u);
    wr(WDT_MODE_ADDR, 8'h60);
    wr(WDT_REFRESH_ADDR, 8'h00);
    hold(5000);
    chk("stopped", 32'h0, wrst);
    rd(WDT_MODE_ADDR, 8'h70);
    chk("unstoppable reset", 32'h67, rdata_u);
    conclude();
  end
endmodule
